// [cmcl_core.sv]
// Purpose: Cascaded position, speed and current loops with set-point sourcing per mode
// Assumes: Set-point and feedback inputs are synchronous to i_core_clk
// Notes: All loops update together once per control period
// Notes on behaviour
// [RL1] Loops form a cascade; innermost loop regulates torque via motor current.
// [RL2] Speed loop turns its speed deviation into target torque for torque loop.
// [RL3] Position loop turns its position deviation into target speed for speed loop.
// [RL4] Cyclic modes apply supervisor set-points directly each period, no own profile.
// [RL5] Profile modes generate own trajectory within acceleration, deceleration, speed limits.
// [RL6] Analog modes take set-points from the discrete input source.
// [RL7] Brushed DC: regulate motor current, output voltage magnitude.
// [RL8] Sine brushless: torque and field currents separately, output magnitude and phase.
// [RL9] Block brushless: regulate current amplitude, output voltage magnitude.
// [RL10] Stepper: regulate each phase current directly.
// [RL11] Torque regulator is PI; gain 32-bit milliohm, reset time 150 to 2600 us.
// [RL12] Separate field current PI regulator with same parameter layout.
// [RL13] Cyclic torque mode takes torque set-point from supervisor object.
// [RL14] With speed loop active, torque set-point is speed loop output.
// [RL15] Torque values relative; 1000 means motor rated torque.
// [RL16] Field current set-point is normally zero.
// [RL17] Nonzero field set-point applied while motor supply exceeds its limit.
// [RL18] Torque deviation is set-point minus internally measured motor current.
// [RL19] Integrator should choose motor rated current above 30% of device rating.
// [RL20] Torque set-point clamped to separate positive and negative limits, default 6000.
// [RL21] PI updates each period: gain times (error plus integral over reset time), saturated.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module cmcl_core #(
	parameter int CTRL_PERIOD_CYC = cmcl_pkg::CTRL_PERIOD_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [cmcl_pkg::ADDR_W-1:0] i_addr,
	input wire logic [cmcl_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [cmcl_pkg::DATA_W-1:0] o_rdata,
	input wire cmcl_pkg::cmcl_setpt_t i_cyclic,
	input wire cmcl_pkg::cmcl_setpt_t i_analog,
	input wire cmcl_pkg::cmcl_fbk_t i_feedback,
	input wire logic i_supply_over_limit,
	output cmcl_pkg::cmcl_drive_t o_drive,
	output logic signed [15:0] o_torque_target,
	output logic o_ctrl_strobe
);
	import cmcl_pkg::*;

	// ==========================================================
	// Helper functions
	// Saturate a wide value to a symmetric 16-bit limit
	function automatic logic signed [15:0] sat16(input logic signed [63:0] v, input logic signed [15:0] lim);
		logic signed [63:0] l;
		l = 64'(lim);
		if (v > l) begin
			return lim;
		end else if (v < -l) begin
			return -lim;
		end
		return v[15:0];
	endfunction

	// Keep reset time inside its legal range
	function automatic logic [15:0] tn_limit(input logic [15:0] tn);
		if (tn < TN_MIN) begin
			return TN_MIN;
		end else if (tn > TN_MAX) begin
			return TN_MAX;
		end
		return tn;
	endfunction

	// Proportional-integral output from error and integral
	function automatic logic signed [15:0] pi_calc(input logic signed [31:0] err, input logic signed [31:0] integ,
		input logic [31:0] gain, input logic [15:0] tn);
		logic signed [63:0] sum;
		logic signed [63:0] prod;
		sum = 64'(err) + 64'(integ) / $signed({48'h0, tn_limit(tn)}); // RL11
		prod = sum * $signed({32'h0, gain}) / GAIN_SCALE; // RL21
		return sat16(prod, VOLT_MAX); // RL21
	endfunction

	// Accumulate integral with windup clamp
	function automatic logic signed [31:0] integ_step(input logic signed [31:0] integ, input logic signed [31:0] err);
		logic signed [63:0] s;
		s = 64'(integ) + 64'(err) * 64'(CTRL_PERIOD_US);
		if (s > 64'(INTEG_LIM)) begin
			return INTEG_LIM;
		end else if (s < -64'(INTEG_LIM)) begin
			return -INTEG_LIM;
		end
		return s[31:0];
	endfunction

	// Proportional outer loop with 8-bit fractional gain
	function automatic logic signed [31:0] p_loop(input logic signed [31:0] err, input logic [15:0] gain);
		logic signed [63:0] p;
		p = (64'(err) * $signed({48'h0, gain})) >>> LOOP_GAIN_SHIFT;
		return p[31:0];
	endfunction

	function automatic logic signed [31:0] abs32(input logic signed [31:0] v);
		return (v < 0) ? -v : v;
	endfunction

	// Move a profile speed toward a target within acceleration limits
	function automatic logic signed [31:0] ramp(input logic signed [31:0] cur, input logic signed [31:0] tgt,
		input logic [31:0] acc, input logic [31:0] dec);
		logic signed [31:0] step;
		logic grow;
		grow = (tgt >= cur && cur >= 0) || (tgt <= cur && cur <= 0);
		step = grow ? $signed(acc) : $signed(dec); // RL5
		if (tgt > cur + step) begin
			return cur + step;
		end else if (tgt < cur - step) begin
			return cur - step;
		end
		return tgt;
	endfunction

	// ==========================================================
	// Registers and state
	logic [2:0] mode_code;
	logic [1:0] motor_code;
	logic [31:0] current_loop_gain;
	logic [15:0] current_loop_reset_time;
	logic [31:0] field_loop_gain;
	logic [15:0] field_loop_reset_time;
	logic [15:0] tq_lim_pos;
	logic [15:0] tq_lim_neg;
	logic [15:0] spd_gain;
	logic [15:0] pos_gain;
	logic [31:0] accel_lim;
	logic [31:0] decel_lim;
	logic [31:0] vmax_lim;
	logic [15:0] fld_boost;
	logic [15:0] tick_cnt;
	logic tick;
	logic signed [31:0] integ_q;
	logic signed [31:0] integ_d;
	logic signed [31:0] prof_vel;
	cmcl_mode_t mode;
	cmcl_motor_t motor;
	logic signed [31:0] next_vel_cmd;
	logic signed [15:0] next_tq;
	logic signed [15:0] next_fld;
	logic signed [31:0] next_prof_vel;
	logic signed [31:0] err_q;
	logic signed [31:0] err_d;
	logic signed [15:0] vq;
	logic signed [15:0] vd;
	cmcl_drive_t next_drive;
	logic signed [31:0] aq;
	logic signed [31:0] ad;
	logic signed [31:0] mx;
	logic signed [31:0] mn;
	logic signed [63:0] mag;

	// Decode mode and motor codes
	always_comb begin
		unique case (mode_code)
			CODE_CYC_POS: mode = cyclic_sync_position_mode;
			CODE_CYC_VEL: mode = cyclic_sync_velocity_mode;
			CODE_CYC_TRQ: mode = cyclic_sync_torque_mode;
			CODE_PRF_POS: mode = profile_position_mode;
			CODE_PRF_VEL: mode = profile_velocity_mode;
			CODE_ANA_POS: mode = analog_position_mode;
			CODE_ANA_VEL: mode = analog_velocity_mode;
			CODE_ANA_TRQ: mode = analog_torque_mode;
		endcase
		unique case (motor_code)
			CODE_MOT_DC: motor = MOTOR_DC;
			CODE_MOT_BL_SINE: motor = MOTOR_BL_SINE;
			CODE_MOT_BL_BLOCK: motor = MOTOR_BL_BLOCK;
			CODE_MOT_STEPPER: motor = MOTOR_STEPPER;
		endcase
	end

	// ==========================================================
	// Register write port
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mode_code <= CODE_CYC_POS;
			motor_code <= CODE_MOT_DC;
			current_loop_gain <= GAIN_RST;
			current_loop_reset_time <= TN_RST;
			field_loop_gain <= GAIN_RST;
			field_loop_reset_time <= TN_RST;
			tq_lim_pos <= TQ_LIM_RST;
			tq_lim_neg <= TQ_LIM_RST;
			spd_gain <= LOOP_GAIN_RST;
			pos_gain <= LOOP_GAIN_RST;
			accel_lim <= ACCEL_RST;
			decel_lim <= ACCEL_RST;
			vmax_lim <= VMAX_RST;
			fld_boost <= FLD_BOOST_RST;
		end else if (i_wr) begin
			unique case (i_addr)
				ADDR_MODE: mode_code <= i_wdata[2:0];
				ADDR_MOTOR: motor_code <= i_wdata[1:0];
				ADDR_CUR_GAIN: current_loop_gain <= i_wdata; // RL11
				ADDR_CUR_TN: current_loop_reset_time <= i_wdata[15:0]; // RL11
				ADDR_FLD_GAIN: field_loop_gain <= i_wdata; // RL12
				ADDR_FLD_TN: field_loop_reset_time <= i_wdata[15:0]; // RL12
				ADDR_TQ_LIM_POS: tq_lim_pos <= i_wdata[15:0];
				ADDR_TQ_LIM_NEG: tq_lim_neg <= i_wdata[15:0];
				ADDR_SPD_GAIN: spd_gain <= i_wdata[15:0];
				ADDR_POS_GAIN: pos_gain <= i_wdata[15:0];
				ADDR_ACCEL: accel_lim <= i_wdata;
				ADDR_DECEL: decel_lim <= i_wdata;
				ADDR_VMAX: vmax_lim <= i_wdata;
				ADDR_FLD_BOOST: fld_boost <= i_wdata[15:0];
				default: ;
			endcase
		end
	end

	// Register read port, data valid only in the cycle after the strobe
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			unique case (i_addr)
				ADDR_CUR_COUNT: o_rdata <= {24'h00_0000, PARAM_COUNT};
				ADDR_FLD_COUNT: o_rdata <= {24'h00_0000, PARAM_COUNT};
				ADDR_MODE: o_rdata <= {29'h0000_0000, mode_code};
				ADDR_MOTOR: o_rdata <= {30'h0000_0000, motor_code};
				ADDR_CUR_GAIN: o_rdata <= current_loop_gain;
				ADDR_CUR_TN: o_rdata <= {16'h0000, current_loop_reset_time};
				ADDR_FLD_GAIN: o_rdata <= field_loop_gain;
				ADDR_FLD_TN: o_rdata <= {16'h0000, field_loop_reset_time};
				ADDR_TQ_LIM_POS: o_rdata <= {16'h0000, tq_lim_pos};
				ADDR_TQ_LIM_NEG: o_rdata <= {16'h0000, tq_lim_neg};
				ADDR_SPD_GAIN: o_rdata <= {16'h0000, spd_gain};
				ADDR_POS_GAIN: o_rdata <= {16'h0000, pos_gain};
				ADDR_ACCEL: o_rdata <= accel_lim;
				ADDR_DECEL: o_rdata <= decel_lim;
				ADDR_VMAX: o_rdata <= vmax_lim;
				ADDR_FLD_BOOST: o_rdata <= {16'h0000, fld_boost};
				ADDR_STATUS: o_rdata <= {o_torque_target, next_fld};
				ADDR_VOLT: o_rdata <= o_drive;
				default: o_rdata <= 32'h0000_0000;
			endcase
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// Control period timer
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tick_cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (tick_cnt == 16'(CTRL_PERIOD_CYC - 1)) begin
			tick_cnt <= 16'h0000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
			tick <= 1'b0;
		end
	end

	// ==========================================================
	// Set-point sourcing and outer loops
	always_comb begin
		logic signed [31:0] pos_err;
		logic signed [31:0] vmax_s;
		logic signed [31:0] tgt;
		logic signed [63:0] brake;
		logic signed [63:0] tq_wide;
		logic speed_active;
		pos_err = 32'sh0000_0000;
		vmax_s = $signed(vmax_lim);
		tgt = 32'sh0000_0000;
		brake = 64'sh0;
		next_prof_vel = prof_vel;
		next_vel_cmd = 32'sh0000_0000;
		speed_active = 1'b1;
		tq_wide = 64'sh0;
		unique case (mode)
			cyclic_sync_position_mode: begin
				pos_err = i_cyclic.position - i_feedback.position; // RL4
				next_vel_cmd = p_loop(pos_err, pos_gain); // RL3
			end
			analog_position_mode: begin
				pos_err = i_analog.position - i_feedback.position; // RL6
				next_vel_cmd = p_loop(pos_err, pos_gain); // RL3
			end
			profile_position_mode: begin
				pos_err = i_cyclic.position - i_feedback.position;
				brake = 64'(prof_vel) * 64'(prof_vel);
				if (brake >= 64'(abs32(pos_err)) * 64'($signed(decel_lim)) * 64'sd2) begin
					tgt = 32'sh0000_0000; // RL5
				end else begin
					tgt = (pos_err < 0) ? -vmax_s : vmax_s; // RL5
				end
				next_prof_vel = ramp(prof_vel, tgt, accel_lim, decel_lim); // RL5
				next_vel_cmd = prof_vel;
			end
			profile_velocity_mode: begin
				tgt = i_cyclic.velocity;
				if (tgt > vmax_s) begin
					tgt = vmax_s;
				end else if (tgt < -vmax_s) begin
					tgt = -vmax_s;
				end
				next_prof_vel = ramp(prof_vel, tgt, accel_lim, decel_lim); // RL5
				next_vel_cmd = prof_vel;
			end
			cyclic_sync_velocity_mode: next_vel_cmd = i_cyclic.velocity; // RL4
			analog_velocity_mode: next_vel_cmd = i_analog.velocity; // RL6
			cyclic_sync_torque_mode: begin
				speed_active = 1'b0;
				tq_wide = 64'(i_cyclic.torque); // RL13
			end
			analog_torque_mode: begin
				speed_active = 1'b0;
				tq_wide = 64'(i_analog.torque); // RL6
			end
		endcase
		if (speed_active) begin
			tq_wide = 64'(p_loop(next_vel_cmd - i_feedback.velocity, spd_gain)); // RL2 RL14
		end
		// Asymmetric clamp in rated-torque-relative units
		if (tq_wide > $signed({48'h0, tq_lim_pos})) begin
			next_tq = $signed(tq_lim_pos); // RL20 RL15
		end else if (tq_wide < -$signed({48'h0, tq_lim_neg})) begin
			next_tq = -$signed(tq_lim_neg); // RL20 RL15
		end else begin
			next_tq = tq_wide[15:0];
		end
		next_fld = i_supply_over_limit ? $signed(fld_boost) : 16'sh0000; // RL16 RL17
	end

	// ==========================================================
	// Inner current loops and voltage output
	always_comb begin
		err_q = 32'(next_tq) - 32'(i_feedback.torque_current_component); // RL18 RL1
		err_d = 32'(next_fld) - 32'(i_feedback.field_current_component); // RL12
		vq = pi_calc(err_q, integ_q, current_loop_gain, current_loop_reset_time); // RL11
		vd = pi_calc(err_d, integ_d, field_loop_gain, field_loop_reset_time); // RL12
		aq = abs32(32'(vq));
		ad = abs32(32'(vd));
		mx = (aq > ad) ? aq : ad;
		mn = (aq > ad) ? ad : aq;
		mag = 64'(mx) + 64'(mn >>> 1);
		next_drive.magnitude = vq; // RL7 RL9
		next_drive.phase = 16'sh0000;
		unique case (motor)
			MOTOR_DC: ;
			MOTOR_BL_BLOCK: ;
			MOTOR_BL_SINE: begin
				next_drive.magnitude = sat16(mag, VOLT_MAX); // RL8
				next_drive.phase = (mag == 64'sh0) ? 16'sh0000 :
					sat16(64'(vd) * 64'(PHASE_QUARTER) / mag, VOLT_MAX); // RL8
			end
			MOTOR_STEPPER: begin
				next_drive.magnitude = vq; // RL10
				next_drive.phase = vd; // RL10
			end
		endcase
	end

	// Integrators and profile state step once per period
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			integ_q <= 32'sh0000_0000;
			integ_d <= 32'sh0000_0000;
			prof_vel <= 32'sh0000_0000;
		end else if (tick) begin
			integ_q <= integ_step(integ_q, err_q); // RL21
			integ_d <= integ_step(integ_d, err_d); // RL21
			prof_vel <= next_prof_vel;
		end
	end

	// Drive and torque target refresh once per period, the strobe register every cycle
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_drive <= '0;
			o_torque_target <= 16'sh0000;
			o_ctrl_strobe <= 1'b0;
		end else begin
			o_ctrl_strobe <= tick;
			if (tick) begin
				o_drive <= next_drive; // RL21
				o_torque_target <= next_tq;
			end
		end
	end

endmodule

// [cmcl_core_bench.sv]
// Purpose: Self-checking bench for the cascaded current loop block
// Assumes: Short control period of 10 cycles
// Notes: Results are taken two ticks after a change of input, one tick for the first drive check
`timescale 1ns/1ps
module cmcl_core_bench;
	import cmcl_pkg::*;
	// ==========================================================
	// Signals
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [DATA_W-1:0] o_rdata;
	cmcl_setpt_t plan = '0;
	cmcl_setpt_t i_cyclic;
	cmcl_setpt_t i_analog = '{32'sd0, 32'sd0, 16'sd250};
	cmcl_fbk_t i_feedback = '0;
	logic i_supply_over_limit = 1'b0;
	cmcl_drive_t o_drive;
	logic signed [15:0] o_torque_target;
	logic o_ctrl_strobe;
	int n_mismatch = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [15:0] ra[7] = '{ADDR_CUR_GAIN, ADDR_CUR_TN, ADDR_FLD_GAIN, ADDR_FLD_TN, ADDR_TQ_LIM_POS,
		ADDR_TQ_LIM_NEG, ADDR_FLD_BOOST};
	logic [31:0] rv[7] = '{32'd1000, 32'd1000, 32'd1000, 32'd1000, 32'd6000, 32'd6000, 32'd0};
	logic signed [15:0] tq[3] = '{16'sd800, -16'sd700, 16'sd200};
	logic signed [15:0] te[3] = '{16'sd500, -16'sd300, 16'sd200};
	// Clock
	always #5 i_core_clk = ~i_core_clk;
	cmcl_core #(.CTRL_PERIOD_CYC(10)) dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cyclic(i_cyclic),
		.i_analog(i_analog), .i_feedback(i_feedback), .i_supply_over_limit(i_supply_over_limit),
		.o_drive(o_drive), .o_torque_target(o_torque_target), .o_ctrl_strobe(o_ctrl_strobe));
	cmcl_sup sup (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ctrl_strobe(o_ctrl_strobe),
		.i_plan(plan), .o_cyclic(i_cyclic));
	// ==========================================================
	// Tasks
	task automatic end_of_test();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask
	task automatic tick();
		int k;
		k = 0;
		do begin
			@(posedge i_core_clk);
			#1;
			k++;
		end while (o_ctrl_strobe !== 1'b1 && k < 40);
		if (k >= 40) chk(32'h1, 32'h0);
	endtask
	task automatic tick2();
		tick();
		tick();
	endtask
	task automatic do_reset();
		@(posedge i_core_clk);
		i_resetn <= 1'b0;
		repeat (12) @(posedge i_core_clk);
		i_resetn <= 1'b1;
	endtask
	// Cycle ceiling against a hang
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		do_reset();
		rd_chk(ADDR_CUR_COUNT, 32'h0000_0002);
		rd_chk(ADDR_FLD_COUNT, 32'h0000_0002);
		for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i]);
		wr(ADDR_CUR_COUNT, 32'h0000_00ff);
		rd_chk(ADDR_CUR_COUNT, 32'h0000_0002);
		rd_chk(16'h0100, 32'h0000_0000);
		wr(ADDR_FLD_GAIN, 32'hdead_beef);
		rd_chk(ADDR_FLD_GAIN, 32'hdead_beef);
		wr(ADDR_CUR_TN, 32'hffff_0a28);
		rd_chk(ADDR_CUR_TN, 32'h0000_0a28);
		// Cyclic torque through the clamp
		wr(ADDR_MODE, 32'(CODE_CYC_TRQ));
		wr(ADDR_TQ_LIM_POS, 32'd500);
		wr(ADDR_TQ_LIM_NEG, 32'd300);
		for (int i = 0; i < 3; i++) begin
			@(posedge i_core_clk);
			plan.torque <= tq[i];
			tick2();
			chk(32'(o_torque_target), 32'(te[i]));
		end
		rd_chk(ADDR_STATUS, {16'd200, 16'd0});
		// Field boost while supply is over its limit
		wr(ADDR_FLD_BOOST, 32'd123);
		@(posedge i_core_clk);
		i_supply_over_limit <= 1'b1;
		tick2();
		rd_chk(ADDR_STATUS, {16'd200, 16'd123});
		@(posedge i_core_clk);
		i_supply_over_limit <= 1'b0;
		// Analog, speed and position sourcing
		wr(ADDR_MODE, 32'(CODE_ANA_TRQ));
		tick2();
		chk(32'(o_torque_target), 32'd250);
		wr(ADDR_MODE, 32'(CODE_CYC_VEL));
		@(posedge i_core_clk);
		plan.velocity <= 32'sd100;
		i_feedback.velocity <= 32'sd40;
		tick2();
		chk(32'(o_torque_target), 32'd60);
		wr(ADDR_MODE, 32'(CODE_PRF_VEL));
		tick2();
		chk(32'(o_torque_target), -32'sd24);
		@(posedge i_core_clk);
		i_analog.velocity <= 32'sd90;
		wr(ADDR_MODE, 32'(CODE_ANA_VEL));
		tick2();
		chk(32'(o_torque_target), 32'd50);
		wr(ADDR_MODE, 32'(CODE_CYC_POS));
		@(posedge i_core_clk);
		plan <= '{32'sd1000, 32'sd0, 16'sd200};
		i_feedback.position <= 32'sd880;
		tick2();
		chk(32'(o_torque_target), 32'd80);
		@(posedge i_core_clk);
		i_analog.position <= 32'sd950;
		wr(ADDR_MODE, 32'(CODE_ANA_POS));
		tick2();
		chk(32'(o_torque_target), 32'd30);
		wr(ADDR_MODE, 32'(CODE_PRF_POS));
		tick2();
		chk(32'(o_torque_target), 32'd8);
		// Current regulator after a mid-run reset
		@(posedge i_core_clk);
		i_feedback <= '0;
		do_reset();
		wr(ADDR_CUR_TN, 32'h0000_0a28);
		wr(ADDR_MODE, 32'(CODE_CYC_TRQ));
		tick();
		@(posedge i_core_clk);
		i_feedback.torque_current_component <= 16'sd300;
		tick();
		chk(32'(o_drive), {16'hff9c, 16'h0000});
		wr(ADDR_CUR_GAIN, 32'h0010_0000);
		tick2();
		chk(32'(o_drive), {16'h8001, 16'h0000});
		wr(ADDR_MOTOR, 32'(CODE_MOT_BL_BLOCK));
		tick2();
		chk(32'(o_drive), {16'h8001, 16'h0000});
		@(posedge i_core_clk);
		i_feedback.field_current_component <= -16'sd50;
		wr(ADDR_MOTOR, 32'(CODE_MOT_BL_SINE));
		tick2();
		chk(32'(o_drive), {16'h7fff, 16'h0018});
		wr(ADDR_MOTOR, 32'(CODE_MOT_STEPPER));
		tick2();
		chk(32'(o_drive), {16'h8001, 16'h0033});
		end_of_test();
	end
endmodule

// [cmcl_core_chk.sv]
// Purpose: Port checks for the cascaded current loop block
// Assumes: Bound to cmcl_core, limits and motor type mirrored from writes
// Notes: Mirrors are compared as they stood at the tick
`timescale 1ns/1ps
module cmcl_core_chk #(
	parameter int CTRL_PERIOD_CYC = 10
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [cmcl_pkg::ADDR_W-1:0] i_addr,
	input wire logic [cmcl_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [cmcl_pkg::DATA_W-1:0] o_rdata,
	input wire cmcl_pkg::cmcl_drive_t o_drive,
	input wire logic signed [15:0] o_torque_target,
	input wire logic o_ctrl_strobe
);
	import cmcl_pkg::*;
	// ==========================================================
	// Helper state
	logic [15:0] cnt;
	logic seen;
	logic [15:0] pos_lim;
	logic [15:0] neg_lim;
	logic [1:0] motor;
	// Cycles since the last strobe
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt <= 16'h0000;
			seen <= 1'b0;
		end else if (o_ctrl_strobe) begin
			cnt <= 16'h0000;
			seen <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
	// Copies of limit and motor words
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pos_lim <= TQ_LIM_RST;
			neg_lim <= TQ_LIM_RST;
			motor <= CODE_MOT_DC;
		end else if (i_wr) begin
			if (i_addr == ADDR_TQ_LIM_POS) pos_lim <= i_wdata[15:0];
			if (i_addr == ADDR_TQ_LIM_NEG) neg_lim <= i_wdata[15:0];
			if (i_addr == ADDR_MOTOR) motor <= i_wdata[1:0];
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_cur_rd;
		i_rd && i_addr == ADDR_CUR_COUNT;
	endsequence
	sequence s_fld_rd;
		i_rd && i_addr == ADDR_FLD_COUNT;
	endsequence
	AST_CUR_COUNT: assert property (s_cur_rd |=> o_rdata == 32'h0000_0002)
		else $error("current count word wrong");
	AST_FLD_COUNT: assert property (s_fld_rd |=> o_rdata == 32'h0000_0002)
		else $error("field count word wrong");
	AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");
	AST_STROBE_ONE: assert property (o_ctrl_strobe |=> !o_ctrl_strobe)
		else $error("strobe longer than one cycle");
	AST_PERIOD: assert property (o_ctrl_strobe && seen |-> cnt == 16'(CTRL_PERIOD_CYC - 1))
		else $error("control period wrong");
	AST_DRIVE_HOLD: assert property (!o_ctrl_strobe |-> $stable(o_drive))
		else $error("drive changed between ticks");
	AST_TARGET_HOLD: assert property (!o_ctrl_strobe |-> $stable(o_torque_target))
		else $error("torque target changed between ticks");
	AST_TQ_CLAMP: assert property (o_ctrl_strobe |-> int'(o_torque_target) <= int'($past(pos_lim))
		&& int'(o_torque_target) >= -int'($past(neg_lim)))
		else $error("torque target outside limits");
	AST_PHASE_ZERO: assert property (o_ctrl_strobe
		&& ($past(motor) == CODE_MOT_DC || $past(motor) == CODE_MOT_BL_BLOCK) |-> o_drive.phase == 16'sh0000)
		else $error("phase nonzero for magnitude-only motor");
endmodule
bind cmcl_core cmcl_core_chk #(.CTRL_PERIOD_CYC(CTRL_PERIOD_CYC)) u_chk (.i_core_clk(i_core_clk),
	.i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_drive(o_drive), .o_torque_target(o_torque_target), .o_ctrl_strobe(o_ctrl_strobe));

// [cmcl_pkg.sv]
// Purpose: Shared constants, types and register map of the cascaded current loop block
// Assumes: 100 MHz core clock, 32-bit register port with byte addresses
// Notes: Current and torque values use relative scaling, 1000 is motor rated torque
package cmcl_pkg;

	// ==========================================================
	// Bus and timing
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CTRL_PERIOD_NS = 10000;
	localparam int CTRL_PERIOD_US = CTRL_PERIOD_NS / 1000;
	localparam int CTRL_PERIOD_CYC = (CTRL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [15:0] OBJ_CURRENT_LOOP = 16'h2342;
	localparam logic [15:0] OBJ_FIELD_LOOP = 16'h2343;
	localparam logic [ADDR_W-1:0] ADDR_CUR_COUNT = 16'(32'(OBJ_CURRENT_LOOP) * 4);
	localparam logic [ADDR_W-1:0] ADDR_FLD_COUNT = 16'(32'(OBJ_FIELD_LOOP) * 4);
	localparam logic [ADDR_W-1:0] ADDR_MODE = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_MOTOR = 16'h0004;
	localparam logic [ADDR_W-1:0] ADDR_CUR_GAIN = 16'h0010;
	localparam logic [ADDR_W-1:0] ADDR_CUR_TN = 16'h0014;
	localparam logic [ADDR_W-1:0] ADDR_FLD_GAIN = 16'h0018;
	localparam logic [ADDR_W-1:0] ADDR_FLD_TN = 16'h001c;
	localparam logic [ADDR_W-1:0] ADDR_TQ_LIM_POS = 16'h0020;
	localparam logic [ADDR_W-1:0] ADDR_TQ_LIM_NEG = 16'h0024;
	localparam logic [ADDR_W-1:0] ADDR_SPD_GAIN = 16'h0028;
	localparam logic [ADDR_W-1:0] ADDR_POS_GAIN = 16'h002c;
	localparam logic [ADDR_W-1:0] ADDR_ACCEL = 16'h0030;
	localparam logic [ADDR_W-1:0] ADDR_DECEL = 16'h0034;
	localparam logic [ADDR_W-1:0] ADDR_VMAX = 16'h0038;
	localparam logic [ADDR_W-1:0] ADDR_FLD_BOOST = 16'h003c;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'h0040;
	localparam logic [ADDR_W-1:0] ADDR_VOLT = 16'h0044;

	// ==========================================================
	// Reset values and limits
	localparam logic [7:0] PARAM_COUNT = 8'h02;
	localparam logic [31:0] GAIN_RST = 32'h0000_03e8;
	localparam logic [15:0] TN_RST = 16'h03e8;
	localparam logic [15:0] TN_MIN = 16'h0096;
	localparam logic [15:0] TN_MAX = 16'h0a28;
	localparam logic [15:0] TQ_LIM_RST = 16'h1770;
	localparam logic [15:0] LOOP_GAIN_RST = 16'h0100;
	localparam logic [31:0] ACCEL_RST = 32'h0000_0010;
	localparam logic [31:0] VMAX_RST = 32'h0000_1000;
	localparam logic [15:0] FLD_BOOST_RST = 16'h0000;
	localparam logic signed [15:0] VOLT_MAX = 16'sh7fff;
	localparam logic signed [31:0] INTEG_LIM = 32'sh0100_0000;
	localparam logic signed [63:0] GAIN_SCALE = 64'sh0000_0000_0000_03e8;
	localparam int LOOP_GAIN_SHIFT = 8;
	localparam logic signed [31:0] PHASE_QUARTER = 32'sh0000_4000;

	// ==========================================================
	// Operating mode codes as written by software
	localparam logic [2:0] CODE_CYC_POS = 3'h0;
	localparam logic [2:0] CODE_CYC_VEL = 3'h1;
	localparam logic [2:0] CODE_CYC_TRQ = 3'h2;
	localparam logic [2:0] CODE_PRF_POS = 3'h3;
	localparam logic [2:0] CODE_PRF_VEL = 3'h4;
	localparam logic [2:0] CODE_ANA_POS = 3'h5;
	localparam logic [2:0] CODE_ANA_VEL = 3'h6;
	localparam logic [2:0] CODE_ANA_TRQ = 3'h7;

	// Motor type codes
	localparam logic [1:0] CODE_MOT_DC = 2'h0;
	localparam logic [1:0] CODE_MOT_BL_SINE = 2'h1;
	localparam logic [1:0] CODE_MOT_BL_BLOCK = 2'h2;
	localparam logic [1:0] CODE_MOT_STEPPER = 2'h3;

	typedef enum logic [7:0] {
		cyclic_sync_position_mode = 8'h01,
		cyclic_sync_velocity_mode = 8'h02,
		cyclic_sync_torque_mode = 8'h04,
		profile_position_mode = 8'h08,
		profile_velocity_mode = 8'h10,
		analog_position_mode = 8'h20,
		analog_velocity_mode = 8'h40,
		analog_torque_mode = 8'h80
	} cmcl_mode_t;

	typedef enum logic [3:0] {
		MOTOR_DC = 4'h1,
		MOTOR_BL_SINE = 4'h2,
		MOTOR_BL_BLOCK = 4'h4,
		MOTOR_STEPPER = 4'h8
	} cmcl_motor_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic signed [31:0] position;
		logic signed [31:0] velocity;
		logic signed [15:0] torque;
	} cmcl_setpt_t;

	typedef struct packed {
		logic signed [31:0] position;
		logic signed [31:0] velocity;
		logic signed [15:0] torque_current_component;
		logic signed [15:0] field_current_component;
	} cmcl_fbk_t;

	typedef struct packed {
		logic signed [15:0] magnitude;
		logic signed [15:0] phase;
	} cmcl_drive_t;

endpackage

// [cmcl_sup.sv]
// Purpose: Supervisory controller model issuing cyclic set-points
// Assumes: Plan values come from the bench
// Notes: Hands over a new set-point once per control period
`timescale 1ns/1ps
module cmcl_sup (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_ctrl_strobe,
	input wire cmcl_pkg::cmcl_setpt_t i_plan,
	output cmcl_pkg::cmcl_setpt_t o_cyclic
);
	import cmcl_pkg::*;
	// Plan value taken over as next set-point after each strobe
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cyclic <= '0;
		end else if (i_ctrl_strobe) begin
			o_cyclic <= i_plan;
		end
	end
endmodule
